//--- hdl/hmc_lane_mapper.sv
// static lane map, polarity correction and lane reversal datapaths
`timescale 1ns/1ps
module hmc_lane_mapper #(
  parameter int              NL       = 8,
  parameter logic [63:0]     LANE_MAP = 64'hFEDCBA9876543210,
  parameter bit              POL_EN   = 1'b1,
  parameter bit              REV_EN   = 1'b1
) (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic [NL*16-1:0]     rx_lane_data,
  input  wire logic [15:0]          pol_inv,
  input  wire logic                 reversed,
  output logic      [NL*16-1:0]     dp_data
);

  typedef struct packed {
    logic [NL*16-1:0] dp;
  } map_state_t;

  map_state_t st;
  map_state_t next_st;

  // one registered datapath per lane, picked through the static table
  always_comb begin
    int src;
    int phys;
    logic [15:0] w;
    src  = 0;
    phys = 0;
    w    = 16'h0000;
    next_st = st;
    for (int n = 0; n < NL; n++) begin
      // reversal sits in front of the table: logical order flips end to end
      src  = (REV_EN && reversed) ? (NL - 1 - n) : n;
      phys = int'(LANE_MAP[src*4 +: 4]);
      w    = rx_lane_data[phys*16 +: 16];
      if (POL_EN && pol_inv[phys]) begin
        w = ~w;
      end
      next_st.dp[n*16 +: 16] = w;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dp_data = st.dp;

endmodule : hmc_lane_mapper

//--- hdl/hmc_wake_lane_ctrl.sv
// link wake sequencing, lane training and register slave
`timescale 1ns/1ps
// Functional notes
// - init enable low holds training idle
// - sleep clear raises power-state pin to wake
// - reset state machine then resets receive path
// - half width eight lanes, full sixteen
// - lane speeds 10, 12.5, 15 Gb/s
// - bus width two to twelve flits
// - system clock matches bus to link bandwidth
// - detect lane polarity, invert when enabled
// - swapped end patterns flag reversed lane order
// - lane order readable, remapped when enabled
// - one receive datapath per lane
// - static table maps datapaths to lanes
// - lowest lane of group is lane zero
// - sleep request drives power-state pin low
// - device pin low puts reset machine asleep
module hmc_wake_lane_ctrl #(
  parameter bit          FULL_WIDTH = 1'b0,
  parameter logic [1:0]  SPEED      = hmc_wake_pkg::SPEED_10G,
  parameter int          FLITS      = 2,
  parameter logic [63:0] LANE_MAP   = 64'hFEDCBA9876543210,
  parameter bit          POL_EN     = 1'b1,
  parameter bit          REV_EN     = 1'b1,
  // derived; left as parameters so ports can be sized
  parameter int          NL         = FULL_WIDTH ? hmc_wake_pkg::LANES_FULL
                                                 : hmc_wake_pkg::LANES_HALF
) (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  output logic                    txps,
  input  wire logic               rxps,
  output logic                    rx_reset,
  input  wire logic               rx_reset_done,
  input  wire logic [NL*16-1:0]   rx_lane_data,
  output logic      [NL*16-1:0]   dp_data,
  output logic                    link_up
);

  // reset machine; wake walks through timer, receive reset and wait
  typedef enum logic [2:0] {
    RS_ACTIVE,
    RS_SLEEP_ENTRY,
    RS_SLEEP,
    RS_WAKE,
    RS_RX_RESET,
    RS_RX_WAIT
  } rst_state_t;

  // training: idle until enabled, then lock, then up
  typedef enum logic [1:0] {
    TR_IDLE,
    TR_TRAIN,
    TR_UP
  } train_state_t;

  // all state of the block, registered as one word
  typedef struct packed {
    logic         ack;
    logic [31:0]  dat;
    logic         sleep_req;
    logic         init_en;
    logic         rxps_s1;
    logic         rxps_s2;
    logic         done_s1;
    logic         done_s2;
    logic         txps;
    logic         rx_reset;
    logic         rx_ready;
    rst_state_t   rst_st;
    logic [7:0]   tmr;
    train_state_t tr_st;
    logic [3:0]   lock_cnt;
    logic         link_up;
    logic         reversed;
    logic [15:0]  pol_inv;
  } ctrl_state_t;

  // timers count down to zero, so loads are one less than the span
  localparam logic [7:0] WAKE_LOAD  = 8'(hmc_wake_pkg::WAKE_CYC - 1);
  localparam logic [7:0] RXRST_LOAD = 8'(hmc_wake_pkg::RX_RESET_CYC - 1);
  localparam logic [3:0] LOCK_LAST  = 4'(hmc_wake_pkg::TRAIN_LOCK_CYC - 1);
  localparam logic [7:0] LANES_CODE = 8'(NL);
  localparam logic [3:0] FLITS_CODE = 4'(FLITS);
  localparam logic [15:0] SYSCLK_MHZ =
    16'(hmc_wake_pkg::sys_clk_mhz(NL, SPEED, FLITS));

  // current and next copy of the block state
  ctrl_state_t st;
  ctrl_state_t next_st;

  // prefix of a 16-bit lane word
  function automatic logic [11:0] prefix(input logic [15:0] w);
    prefix = w[15:4];
  endfunction : prefix

  // raw word of physical lane p
  function automatic logic [15:0] lane_word(input logic [NL*16-1:0] d,
                                            input int p);
    lane_word = d[p*16 +: 16];
  endfunction : lane_word

  // a training word in either end-of-link form
  function automatic logic is_pattern(input logic [11:0] p);
    is_pattern = (p == hmc_wake_pkg::PAT_LANE_FIRST) ||
                 (p == hmc_wake_pkg::PAT_LANE_LAST);
  endfunction : is_pattern

  // register read mux; unmapped addresses read zero
  function automatic logic [31:0] read_reg(input logic [7:0] a,
                                           input ctrl_state_t s);
    read_reg = 32'h0000_0000;
    unique case (a)
      hmc_wake_pkg::MAIN_CONFIG_ADDR: begin
        read_reg[hmc_wake_pkg::MAIN_SLEEP_BIT]    = s.sleep_req;
        read_reg[hmc_wake_pkg::MAIN_RX_READY_BIT] = s.rx_ready;
      end
      hmc_wake_pkg::LINK_INIT_CTRL_ADDR: begin
        read_reg[hmc_wake_pkg::INIT_EN_BIT] = s.init_en;
      end
      hmc_wake_pkg::LINK_STATUS_ADDR: begin
        read_reg[hmc_wake_pkg::LINK_UP_BIT] = s.link_up;
      end
      hmc_wake_pkg::LANE_STATUS_ADDR: begin
        read_reg[15:0] = s.pol_inv;
        read_reg[hmc_wake_pkg::LANE_REV_BIT] = s.reversed;
      end
      hmc_wake_pkg::LINK_CONFIG_ADDR: begin
        read_reg[hmc_wake_pkg::CFG_LANES_LSB +: 8]   = LANES_CODE;
        read_reg[hmc_wake_pkg::CFG_SPEED_LSB +: 2]   = SPEED;
        read_reg[hmc_wake_pkg::CFG_FLITS_LSB +: 4]   = FLITS_CODE;
        read_reg[hmc_wake_pkg::CFG_SYSCLK_LSB +: 16] = SYSCLK_MHZ;
      end
      default: read_reg = 32'h0000_0000;
    endcase
  endfunction : read_reg

  // corrected word of logical datapath n before any reversal
  function automatic logic [15:0] dp_word(input logic [NL*16-1:0] d,
                                          input logic [15:0] inv,
                                          input int n);
    int p;
    p = int'(LANE_MAP[n*4 +: 4]);
    dp_word = lane_word(d, p);
    if (inv[p]) begin
      dp_word = ~dp_word;
    end
  endfunction : dp_word

  // next-state logic for bus, wake sequencing and training
  always_comb begin
    logic        req;
    logic [15:0] inv_now;
    logic [11:0] p_first;
    logic [11:0] p_last;
    req     = 1'b0;
    inv_now = 16'h0000;
    p_first = 12'h000;
    p_last  = 12'h000;
    next_st = st;

    // pin synchronisers; only stage two is used below
    next_st.rxps_s1 = rxps;
    next_st.rxps_s2 = st.rxps_s1;
    next_st.done_s1 = rx_reset_done;
    next_st.done_s2 = st.done_s1;

    // classic wishbone: ack one cycle after the strobe, then drop
    req = wb_cyc_i && wb_stb_i && !st.ack;
    next_st.ack = req;
    next_st.dat = req ? read_reg(wb_adr_i, st) : st.dat;
    if (req && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        hmc_wake_pkg::MAIN_CONFIG_ADDR:
          next_st.sleep_req = wb_dat_i[hmc_wake_pkg::MAIN_SLEEP_BIT];
        hmc_wake_pkg::LINK_INIT_CTRL_ADDR:
          next_st.init_en = wb_dat_i[hmc_wake_pkg::INIT_EN_BIT];
        default: ;
      endcase
    end

    // reset state machine: sleep entry and wake recovery
    unique case (st.rst_st)
      RS_ACTIVE: begin
        // link drops at once; receive reset waits for the device
        if (st.sleep_req) begin
          next_st.txps     = 1'b0;
          next_st.rx_ready = 1'b0;
          next_st.rst_st   = RS_SLEEP_ENTRY;
        end
      end
      RS_SLEEP_ENTRY: begin
        if (!st.rxps_s2) begin
          next_st.rst_st   = RS_SLEEP;
          next_st.rx_reset = 1'b1;
        end else if (!st.sleep_req) begin
          // wake requested before the device ever slept
          next_st.txps   = 1'b1;
          next_st.tmr    = WAKE_LOAD;
          next_st.rst_st = RS_WAKE;
        end
      end
      RS_SLEEP: begin
        if (!st.sleep_req) begin
          next_st.txps   = 1'b1;
          next_st.tmr    = WAKE_LOAD;
          next_st.rst_st = RS_WAKE;
        end
      end
      RS_WAKE: begin
        // give the device time to leave sleep before the receiver restarts
        if (st.tmr == 8'h00) begin
          next_st.rx_reset = 1'b1;
          next_st.tmr      = RXRST_LOAD;
          next_st.rst_st   = RS_RX_RESET;
        end else begin
          next_st.tmr = st.tmr - 8'h01;
        end
      end
      RS_RX_RESET: begin
        if (st.tmr == 8'h00) begin
          next_st.rx_reset = 1'b0;
          next_st.rst_st   = RS_RX_WAIT;
        end else begin
          next_st.tmr = st.tmr - 8'h01;
        end
      end
      RS_RX_WAIT: begin
        if (st.done_s2) begin
          next_st.rx_ready = 1'b1;
          next_st.rst_st   = RS_ACTIVE;
        end
      end
      default: begin
        // unused code: recover through a fresh receive reset
        next_st.rx_reset = 1'b1;
        next_st.tmr      = RXRST_LOAD;
        next_st.rst_st   = RS_RX_RESET;
      end
    endcase

    // polarity seen this cycle on each physical lane
    for (int p = 0; p < NL; p++) begin
      inv_now[p] = is_pattern(~prefix(lane_word(rx_lane_data, p)));
    end
    p_first = prefix(dp_word(rx_lane_data, st.pol_inv, 0));
    p_last  = prefix(dp_word(rx_lane_data, st.pol_inv, NL - 1));

    // training machine; held idle without enable or receive path
    if (!st.init_en || !st.rx_ready) begin
      next_st.tr_st    = TR_IDLE;
      next_st.link_up  = 1'b0;
      next_st.lock_cnt = 4'h0;
    end else begin
      unique case (st.tr_st)
        TR_IDLE: begin
          next_st.tr_st    = TR_TRAIN;
          next_st.pol_inv  = 16'h0000;
          next_st.reversed = 1'b0;
          next_st.lock_cnt = 4'h0;
        end
        TR_TRAIN: begin
          // sticky once seen; a lane never flips back mid-training
          next_st.pol_inv = st.pol_inv | inv_now;
          if (p_first == hmc_wake_pkg::PAT_LANE_LAST &&
              p_last == hmc_wake_pkg::PAT_LANE_FIRST) begin
            next_st.reversed = 1'b1;
          end
          if (is_pattern(p_first) && is_pattern(p_last)) begin
            if (st.lock_cnt == LOCK_LAST) begin
              next_st.tr_st   = TR_UP;
              next_st.link_up = 1'b1;
            end else begin
              next_st.lock_cnt = st.lock_cnt + 4'h1;
            end
          end else begin
            next_st.lock_cnt = 4'h0;
          end
        end
        TR_UP: begin
          next_st.link_up = 1'b1;
        end
        default: next_st.tr_st = TR_IDLE;
      endcase
    end
  end

  // single state register; receive path is brought up after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      st           <= '0;
      st.sleep_req <= hmc_wake_pkg::MAIN_SLEEP_RST;
      st.init_en   <= hmc_wake_pkg::INIT_EN_RST;
      st.txps      <= hmc_wake_pkg::TXPS_RST;
      st.rxps_s1   <= 1'b1;
      st.rxps_s2   <= 1'b1;
      st.rx_reset  <= 1'b1;
      st.tmr       <= RXRST_LOAD;
      st.rst_st    <= RS_RX_RESET;
      st.tr_st     <= TR_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // per-lane datapaths after table, polarity and reversal
  hmc_lane_mapper #(
    .NL       (NL),
    .LANE_MAP (LANE_MAP),
    .POL_EN   (POL_EN),
    .REV_EN   (REV_EN)
  ) u_mapper (
    .clk          (clk),
    .srst         (srst),
    .rx_lane_data (rx_lane_data),
    .pol_inv      (st.pol_inv),
    .reversed     (st.reversed),
    .dp_data      (dp_data)
  );

  // outputs come straight from the state register
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  assign txps     = st.txps;
  assign rx_reset = st.rx_reset;
  assign link_up  = st.link_up;

endmodule : hmc_wake_lane_ctrl

//--- hdl/hmc_wake_pkg.sv
// constants shared by the link wake and lane alignment logic
package hmc_wake_pkg;

  // register byte addresses
  localparam logic [7:0] MAIN_CONFIG_ADDR    = 8'h00;
  localparam logic [7:0] LINK_INIT_CTRL_ADDR = 8'h10;
  localparam logic [7:0] LINK_STATUS_ADDR    = 8'h14;
  localparam logic [7:0] LANE_STATUS_ADDR    = 8'h18;
  localparam logic [7:0] LINK_CONFIG_ADDR    = 8'h1C;

  // field positions
  localparam int MAIN_RX_READY_BIT = 0;
  localparam int MAIN_SLEEP_BIT    = 1;
  localparam int INIT_EN_BIT       = 1;
  localparam int LINK_UP_BIT       = 17;
  localparam int LANE_REV_BIT      = 16;
  localparam int CFG_LANES_LSB     = 0;
  localparam int CFG_SPEED_LSB     = 8;
  localparam int CFG_FLITS_LSB     = 12;
  localparam int CFG_SYSCLK_LSB    = 16;

  // reset values of software controls
  localparam logic MAIN_SLEEP_RST = 1'b0;
  localparam logic INIT_EN_RST    = 1'b0;
  localparam logic TXPS_RST       = 1'b1;

  // link geometry
  localparam int LANES_HALF = 8;
  localparam int LANES_FULL = 16;
  localparam int FLIT_BITS  = 128;
  localparam int FLITS_MIN  = 2;
  localparam int FLITS_MAX  = 12;
  localparam int WORD_W     = 16;
  localparam int PAT_W      = 12;

  // training word prefixes, low nibble is don't care
  localparam logic [11:0] PAT_LANE_FIRST = 12'hF03;
  localparam logic [11:0] PAT_LANE_LAST  = 12'hF0C;

  // lane speed codes
  localparam logic [1:0] SPEED_10G   = 2'h0;
  localparam logic [1:0] SPEED_12G5  = 2'h1;
  localparam logic [1:0] SPEED_15G   = 2'h2;

  // timing
  localparam int CLK_MHZ         = 40;
  localparam int RX_RESET_NS     = 100;
  localparam int WAKE_NS         = 1000;
  localparam int RX_RESET_CYC    = (RX_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYC        = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int TRAIN_LOCK_CYC  = 8;

  // per-lane rate in Mb/s for a speed code
  function automatic int lane_rate_mbps(input logic [1:0] code);
    unique case (code)
      SPEED_12G5: lane_rate_mbps = 12500;
      SPEED_15G:  lane_rate_mbps = 15000;
      default:    lane_rate_mbps = 10000;
    endcase
  endfunction : lane_rate_mbps

  // system clock in MHz that matches bus bandwidth to link bandwidth
  function automatic int sys_clk_mhz(input int lanes, input logic [1:0] code,
                                     input int flits);
    sys_clk_mhz = (lanes * lane_rate_mbps(code)) / (flits * FLIT_BITS);
  endfunction : sys_clk_mhz

endpackage : hmc_wake_pkg

//--- tb/hmc_dev_model.sv
// behavioural memory cube device on the serial lanes
`timescale 1ns/1ps
module hmc_dev_model #(
  parameter int NL = 8
) (
  input  wire logic             clk,
  input  wire logic             txps,
  input  wire logic             rx_reset,
  input  wire logic             inv_lane0,
  input  wire logic             swap_ends,
  output logic                  rxps,
  output logic                  rx_reset_done,
  output logic      [NL*16-1:0] rx_lane_data
);
  logic [2:0] ps_dly   = 3'h7;
  logic [3:0] done_cnt = 4'h0;
  logic [3:0] tick     = 4'h0;

  // device follows the power pin late, as a slow part would
  always_ff @(posedge clk) begin
    ps_dly <= {ps_dly[1:0], txps};
    tick   <= tick + 4'h1;
    if (rx_reset)
      done_cnt <= 4'h0;
    else if (done_cnt != 4'hF)
      done_cnt <= done_cnt + 4'h1;
  end
  assign rxps          = ps_dly[2];
  assign rx_reset_done = (done_cnt >= 4'h5);

  // end lanes carry the end patterns, swapped when asked
  always_comb begin
    int         l;
    logic [15:0] w;
    l = 0;
    w = 16'h0000;
    for (int p = 0; p < NL; p++) begin
      l = swap_ends ? NL - 1 - p : p;
      w = (l == 0) ? {12'hF03, tick} :
          (l == NL - 1) ? {12'hF0C, tick} : {4'h5, 8'(l), tick};
      if (inv_lane0 && p == 0)
        w = ~w;
      if (rx_reset)
        w = {4{tick}}; // no stale word while the path is in reset
      rx_lane_data[p*16 +: 16] = w;
    end
  end
endmodule : hmc_dev_model

//--- tb/hmc_wake_lane_ctrl_tb_top.sv
// self-checking bench for link wake and lane training
`timescale 1ns/1ps
module hmc_wake_lane_ctrl_tb_top;
  localparam int NL = 8;
  logic             clk      = 1'b0;
  logic             srst     = 1'b1;
  logic             wb_cyc_i = 1'b0;
  logic             wb_stb_i = 1'b0;
  logic             wb_we_i  = 1'b0;
  logic [7:0]       wb_adr_i = 8'h00;
  logic [3:0]       wb_sel_i = 4'h0;
  logic [31:0]      wb_dat_i = 32'h0;
  logic             inv0     = 1'b0;
  logic             swap     = 1'b0;
  logic [31:0]      wb_dat_o, rd;
  logic             wb_ack_o, txps, rxps, rx_reset, rx_reset_done, link_up;
  logic [NL*16-1:0] rx_lane_data, dp_data;
  int               num_errors = 0;
  int               n_compared = 0;

  hmc_wake_lane_ctrl #(.FULL_WIDTH(1'b0)) DUT (
    .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .txps(txps), .rxps(rxps), .rx_reset(rx_reset),
    .rx_reset_done(rx_reset_done), .rx_lane_data(rx_lane_data),
    .dp_data(dp_data), .link_up(link_up));

  hmc_dev_model #(.NL(NL)) u_dev (
    .clk(clk), .txps(txps), .rx_reset(rx_reset), .inv_lane0(inv0),
    .swap_ends(swap), .rxps(rxps), .rx_reset_done(rx_reset_done),
    .rx_lane_data(rx_lane_data));

  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one classic cycle; entered just after a rising edge
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    // a missing answer counts against the run, never passes quietly
    if (wb_ack_o !== 1'b1)
      chk("bus ack", {31'h0, wb_ack_o}, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb

  // bounded poll of one status bit until it reads one
  task poll(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin
      wb(1'b0, a, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 300);
    chk("poll bit", {31'h0, rd[b]}, 32'h1);
  endtask : poll

  task t_reset;
    chk("txps", {31'h0, txps}, 32'h1);
    chk("rx_reset", {31'h0, rx_reset}, 32'h1);
    wb(1'b0, 8'h10, 32'h0);
    chk("init reg", rd, 32'h0);
    wb(1'b1, 8'h08, 32'hFFFFFFFF); // unmapped write is dropped
    wb(1'b0, 8'h08, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1'b0, 8'h1C, 32'h0);
    chk("link config", rd, 32'h01382008);
    poll(8'h00, 0);
    wb(1'b0, 8'h00, 32'h0);
    chk("main reg", rd, 32'h1);
    repeat (20) @(posedge clk);
    chk("idle link", {31'h0, link_up}, 32'h0);
  endtask : t_reset

  // retrain with a given lane fault and judge the lane status
  task t_train(input logic i, input logic s, input logic [31:0] st);
    inv0 <= i;
    swap <= s;
    wb(1'b1, 8'h10, 32'h0);
    wb(1'b1, 8'h10, 32'h2);
    poll(8'h14, 17);
    wb(1'b0, 8'h18, 32'h0);
    chk("lane status", rd, st);
    chk("path0", {20'h0, dp_data[15:4]}, 32'hF03);
    chk("pathN", {20'h0, dp_data[NL*16-1 -: 12]}, 32'hF0C);
  endtask : t_train

  task t_sleep;
    wb(1'b1, 8'h00, 32'h2);
    @(posedge clk);
    chk("sleep pin", {31'h0, txps}, 32'h0);
    chk("sleep link", {31'h0, link_up}, 32'h0);
    repeat (10) @(posedge clk);
    chk("sleep rx", {31'h0, rx_reset}, 32'h1);
    wb(1'b1, 8'h10, 32'h0);
    wb(1'b1, 8'h00, 32'h0);
    chk("wake pin", {31'h0, txps}, 32'h1);
    wb(1'b0, 8'h14, 32'h0);
    chk("link status", {31'h0, rd[17]}, 32'h0);
    poll(8'h00, 0);
    chk("held idle", {31'h0, link_up}, 32'h0);
    wb(1'b1, 8'h10, 32'h2);
    poll(8'h14, 17);
  endtask : t_sleep

  task stop_test;
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_train(1'b0, 1'b0, 32'h0);
    t_train(1'b1, 1'b0, 32'h1);
    t_train(1'b0, 1'b1, 32'h10000);
    t_sleep;
    stop_test;
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    stop_test;
  end
endmodule : hmc_wake_lane_ctrl_tb_top

//--- tb/hmc_wake_props.sv
// wake, power pin and bus timing properties of the link controller
`timescale 1ns/1ps
module hmc_wake_props (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        txps,
  input wire logic        rxps,
  input wire logic        rx_reset,
  input wire logic        link_up
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acked next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  reset_out_a: assert property ($fell(srst) |-> txps && rx_reset && !link_up)
    else $error("wrong outputs after reset");
  pin_low_a: assert property (
    wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] && wb_dat_i[1]
    && link_up |-> ##[1:2] !txps)
    else $error("sleep request did not lower power pin");
  sleep_link_a: assert property (!txps |=> !link_up)
    else $error("link up while asleep");
  ready_link_a: assert property (link_up |-> !rx_reset)
    else $error("link up during receive reset");
  dev_sleep_a: assert property (
    !txps && $fell(rxps) |-> ##[1:6] rx_reset)
    else $error("device sleep not followed by receive reset");
  rx_hold_a: assert property (
    $fell(rx_reset) |-> $past(rx_reset, 2) && $past(rx_reset, 4))
    else $error("receive reset shorter than four cycles");
  wake_rx_a: assert property ($rose(txps) |-> ##[1:80] $fell(rx_reset))
    else $error("wake did not cycle receive reset");

  cover property ($fell(txps));
  cover property ($rose(txps));
  cover property ($rose(link_up));
endmodule : hmc_wake_props

bind hmc_wake_lane_ctrl hmc_wake_props u_props (
  .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .txps(txps), .rxps(rxps),
  .rx_reset(rx_reset), .link_up(link_up));
